// ---- verilog/imt_consts.vh ----
`ifndef IMT_CONSTS_VH
`define IMT_CONSTS_VH

// ****************************************************************
// Clock and bus timing
// ****************************************************************
// System clock rate in kHz
`define IMT_SYS_CLK_KHZ 10000
// One quarter of an SCL period in ns (100 kHz bus)
`define IMT_QUARTER_NS 2500

// ****************************************************************
// Byte layout
// ****************************************************************
// Index of the first bit on the wire (MSB first)
`define IMT_MSB 7
// Last value of the bit counter
`define IMT_BIT_LAST 3'h7
// Fixed upper five bits of a first 10-bit address byte
`define IMT_TEN_PREFIX 5'h1e
// Quarter phases inside one SCL bit
`define IMT_Q_RISE 2'h2
`define IMT_Q_LAST 2'h3
`define IMT_Q_FIRST 2'h0
`define IMT_Q_IDLE_START 2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define IMT_RST_BYTE 8'h00
`define IMT_RST_TX_EMPTY 1'b1

`endif

// ---- verilog/imt_i2c_master.v ----
`timescale 1ns/1ps
`include "imt_consts.vh"

// How it works
// [R1] 10-bit first byte is 11110, two MSBs, direction
// [R2] Software loads first 10-bit byte with write bit
// [R3] Software sets enable, then transmit interrupt enable
// [R4] Interrupt while enabled and buffer empty
// [R5] Start condition, then buffer copied to shifter
// [R6] Transmit interrupt after first address bit
// [R7] Sample SDA in ack slot; low sets ack
// [R8] High ack slot sets nack flag, clears ack
// [R9] Software abandons nacked write with stop, flush
// [R10] Stop after nack clears stop and nack flag
// [R11] Second address byte loaded from buffer after ack
// [R12] Transmit interrupt after first bit of data
// [R13] Software sets stop or start during last byte
// [R14] No nack flag when stop/start already pending
// [R15] Pending stop or restart issued, bit cleared
// [R16] Software loads 7-bit address with read bit
// [R17] Software sets nack request for single read
// [R18] Received byte answered by nack request bit
// [R19] Complete received byte sets receive-full flag
// [R20] Buffer read clears receive-full flag
// [R21] Refused final byte raises nack flag
// [R22] Software stops after unacknowledged read address
// [R23] Shifter hidden; only buffer faces software
// [R24] Flush discards pending byte, empty flag set
// [R25] Master makes SCL, MSB first on SDA
module imt_i2c_master #(
    parameter QUARTER_NS = `IMT_QUARTER_NS
) (
    input wire sys_clk,
    input wire rstn,
    input wire controller_enable,
    input wire transmit_irq_enable,
    input wire start_set,
    input wire stop_set,
    input wire flush_set,
    input wire nak_set,
    input wire data_wr,
    input wire [7:0] data_in,
    input wire data_rd,
    output reg [7:0] data_out,
    output reg tx_buffer_empty,
    output reg rx_buffer_full,
    output reg ack_flag,
    output reg nack_irq_flag,
    output reg ten_bit_flag,
    output reg read_flag,
    output reg start_pending,
    output reg stop_pending,
    output reg nak_pending,
    output reg irq,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_n,
    output reg scl_o,
    output reg scl_oe_n
);

    // ****************************************************************
    // Constants and states
    // ****************************************************************
    // Cycles per quarter bit, rounded down so the bus never runs slow past spec
    localparam integer QUARTER_CYC = (QUARTER_NS * `IMT_SYS_CLK_KHZ) / 1000000;
    localparam integer QC = (QUARTER_CYC < 1) ? 1 : QUARTER_CYC;
    localparam integer QC_LAST = QC - 1;
    localparam [15:0] QUARTER_MAX = QC_LAST[15:0];
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_TX = 3'h2;
    localparam [2:0] S_ACK = 3'h3;
    localparam [2:0] S_RX = 3'h4;
    localparam [2:0] S_MACK = 3'h5;
    localparam [2:0] S_WAIT = 3'h6;
    localparam [2:0] S_STOP = 3'h7;

    reg [2:0] state; // Sequencer state
    reg [15:0] qcnt; // Cycle count inside a quarter
    reg [1:0] q; // Quarter inside the current bit
    reg [2:0] bitcnt; // Bits done in the current byte
    reg [7:0] shifter; // Internal shift register, never seen by software
    reg [7:0] data_buf; // Data buffer shared by both directions
    reg addr_byte; // Byte on the wire is an address byte
    reg second_addr; // Next byte is the second 10-bit address byte
    reg refused; // Last received byte was refused
    reg sda_meta; // Synchroniser first stage
    reg sda_sync; // Synchronised SDA
    reg next_scl_rel; // Wanted SCL release
    reg next_sda_rel; // Wanted SDA release
    reg sda_rel_d; // SDA release held back one cycle behind SCL

    wire tick = (qcnt == QUARTER_MAX); // End of a quarter
    wire bit_end = tick && (q == `IMT_Q_LAST); // End of an SCL bit
    wire sample = tick && (q == `IMT_Q_RISE); // Middle of SCL high

    // ****************************************************************
    // SDA input synchroniser
    // ****************************************************************
    // Two stages before any logic looks at the pin
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end
        else
        begin
            sda_meta <= sda_i;
            sda_sync <= sda_meta;
        end
    end

    // ****************************************************************
    // Pin levels per state and quarter
    // ****************************************************************
    // SCL low in the first half of each bit, released in the second half
    always @*
    begin
        next_scl_rel = 1'b1;
        next_sda_rel = 1'b1;
        case (state)
            S_IDLE:
            begin
                next_scl_rel = 1'b1;
                next_sda_rel = 1'b1;
            end
            S_START:
            begin
                // Release, pull SDA under high SCL, then pull SCL
                next_scl_rel = (q == 2'h1) || (q == `IMT_Q_RISE);
                next_sda_rel = (q == `IMT_Q_FIRST) || (q == 2'h1);
            end
            S_TX:
            begin
                next_scl_rel = q[1];
                next_sda_rel = shifter[`IMT_MSB]; // [R25]
            end
            S_ACK, S_RX:
            begin
                next_scl_rel = q[1];
                next_sda_rel = 1'b1;
            end
            S_MACK:
            begin
                next_scl_rel = q[1];
                next_sda_rel = refused; // [R18]
            end
            S_WAIT:
            begin
                // Hold the clock low while software catches up
                next_scl_rel = 1'b0;
                next_sda_rel = 1'b1;
            end
            S_STOP:
            begin
                // SDA rises while SCL is high
                next_scl_rel = (q != `IMT_Q_FIRST);
                next_sda_rel = q[1];
            end
            default:
            begin
                next_scl_rel = 1'b1;
                next_sda_rel = 1'b1;
            end
        endcase
    end

    // ****************************************************************
    // Pin registers
    // ****************************************************************
    // Open drain: the enable is low only when pulling the line low
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_oe_n <= 1'b1;
            sda_rel_d <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            scl_oe_n <= next_scl_rel; // [R25]
            // SDA moves a cycle after SCL, so it never changes on an SCL fall
            sda_rel_d <= next_sda_rel;
            sda_oe_n <= sda_rel_d;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Sequencer, buffer and flags
    // ****************************************************************
    // Hardware clears come first so a software set in the same cycle wins
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= S_IDLE;
            qcnt <= 16'h0000;
            q <= `IMT_Q_FIRST;
            bitcnt <= 3'h0;
            shifter <= `IMT_RST_BYTE;
            data_buf <= `IMT_RST_BYTE;
            data_out <= `IMT_RST_BYTE;
            addr_byte <= 1'b0;
            second_addr <= 1'b0;
            refused <= 1'b0;
            tx_buffer_empty <= `IMT_RST_TX_EMPTY;
            rx_buffer_full <= 1'b0;
            ack_flag <= 1'b0;
            nack_irq_flag <= 1'b0;
            ten_bit_flag <= 1'b0;
            read_flag <= 1'b0;
            start_pending <= 1'b0;
            stop_pending <= 1'b0;
            nak_pending <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            qcnt <= (tick || state == S_IDLE) ? 16'h0000 : qcnt + 16'h0001;
            if (tick)
                q <= q + 2'h1;
            // Software side of the buffer
            if (data_rd)
                rx_buffer_full <= 1'b0; // [R20]
            case (state)
                S_IDLE:
                begin
                    q <= `IMT_Q_IDLE_START;
                    if (controller_enable && start_pending)
                        state <= S_START;
                end
                S_START:
                begin
                    if (bit_end)
                    begin
                        // Start done: take the address byte from the buffer
                        shifter <= data_buf; // [R5]
                        start_pending <= 1'b0; // [R15]
                        addr_byte <= 1'b1;
                        refused <= 1'b0;
                        read_flag <= data_buf[0];
                        // First byte with the fixed prefix: 10-bit target; with the write bit a second address byte follows
                        ten_bit_flag <= (data_buf[7:3] == `IMT_TEN_PREFIX); // [R1]
                        second_addr <= (data_buf[7:3] == `IMT_TEN_PREFIX) && !data_buf[0]; // [R1]
                        bitcnt <= 3'h0;
                        state <= S_TX;
                    end
                end
                S_TX:
                begin
                    if (bit_end)
                    begin
                        shifter <= {shifter[6:0], 1'b0}; // [R25]
                        bitcnt <= bitcnt + 3'h1;
                        // Buffer freed once the first bit is on the wire
                        if (bitcnt == 3'h0)
                            tx_buffer_empty <= 1'b1; // [R6] [R11] [R12]
                        if (bitcnt == `IMT_BIT_LAST)
                            state <= S_ACK;
                    end
                end
                S_ACK:
                begin
                    if (sample)
                    begin
                        ack_flag <= !sda_sync; // [R7]
                        // Pending stop or start masks the nack event
                        if (sda_sync && !stop_pending && !start_pending)
                            nack_irq_flag <= 1'b1; // [R8] [R14]
                    end
                    if (bit_end)
                    begin
                        addr_byte <= second_addr;
                        second_addr <= 1'b0;
                        bitcnt <= 3'h0;
                        if (stop_pending)
                            state <= S_STOP; // [R15]
                        else if (start_pending)
                            state <= S_START; // [R15]
                        else if (!ack_flag)
                            state <= S_WAIT;
                        else if (read_flag && addr_byte && !second_addr)
                            state <= S_RX;
                        else if (!tx_buffer_empty)
                        begin
                            // Second address byte or next data byte
                            shifter <= data_buf; // [R11] [R23]
                            state <= S_TX;
                        end
                        else
                            state <= S_WAIT;
                    end
                end
                S_RX:
                begin
                    if (sample)
                        shifter <= {shifter[6:0], sda_sync}; // [R25]
                    if (bit_end)
                    begin
                        bitcnt <= bitcnt + 3'h1;
                        if (bitcnt == `IMT_BIT_LAST)
                        begin
                            data_buf <= shifter; // [R23]
                            data_out <= shifter; // [R23]
                            rx_buffer_full <= 1'b1; // [R19]
                            // Answer frozen here; a later nak request is for the next byte
                            refused <= nak_pending; // [R18]
                            state <= S_MACK;
                        end
                    end
                end
                S_MACK:
                begin
                    if (bit_end)
                    begin
                        bitcnt <= 3'h0;
                        if (refused)
                        begin
                            nack_irq_flag <= 1'b1; // [R21]
                            nak_pending <= 1'b0;
                        end
                        state <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    q <= `IMT_Q_FIRST;
                    if (stop_pending)
                        state <= S_STOP; // [R10]
                    else if (start_pending)
                        state <= S_START;
                    else if (read_flag && !refused && !rx_buffer_full && !nack_irq_flag)
                        state <= S_RX;
                    else if (!read_flag && !nack_irq_flag && !tx_buffer_empty)
                    begin
                        shifter <= data_buf; // [R12]
                        state <= S_TX;
                    end
                end
                S_STOP:
                begin
                    if (bit_end)
                    begin
                        stop_pending <= 1'b0; // [R10] [R15]
                        nack_irq_flag <= 1'b0; // [R10]
                        state <= S_IDLE;
                    end
                end
                default:
                    state <= S_IDLE;
            endcase
            // Disabling the controller drops any transfer at once
            if (!controller_enable)
                state <= S_IDLE;
            // Software sets last, so they win over hardware clears
            if (flush_set)
                tx_buffer_empty <= 1'b1; // [R24]
            if (data_wr)
            begin
                data_buf <= data_in;
                data_out <= data_in;
                tx_buffer_empty <= 1'b0;
            end
            if (start_set)
                start_pending <= 1'b1;
            if (stop_set)
                stop_pending <= 1'b1;
            if (nak_set)
                nak_pending <= 1'b1;
            // One interrupt for empty, full and nack events
            irq <= controller_enable && ((transmit_irq_enable && tx_buffer_empty) ||
                   rx_buffer_full || nack_irq_flag); // [R4]
        end
    end

endmodule // imt_i2c_master

// ---- test/imt_i2c_master_chk.sv ----
`timescale 1ns/1ps
// ****************
// Port checks on the master
// ****************
module imt_i2c_master_chk (
    input wire sys_clk,
    input wire rstn,
    input wire controller_enable,
    input wire transmit_irq_enable,
    input wire flush_set,
    input wire data_wr,
    input wire [7:0] data_in,
    input wire data_rd,
    input wire [7:0] data_out,
    input wire tx_buffer_empty,
    input wire rx_buffer_full,
    input wire ack_flag,
    input wire nack_irq_flag,
    input wire read_flag,
    input wire start_pending,
    input wire stop_pending,
    input wire irq,
    input wire sda_oe_n,
    input wire scl_oe_n
);
    // One domain, so clock and reset are given once
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // Interrupt is the enabled sources, one clock late
    irq_lag_a: assert property (
        irq == $past(controller_enable && (transmit_irq_enable && tx_buffer_empty || rx_buffer_full || nack_irq_flag)))
        else $error("irq lag wrong");
    // Software only ever sees the buffer
    write_buf_a: assert property (
        data_wr && !flush_set |=> data_out == $past(data_in)) else $error("buffer write lost");
    flush_empty_a: assert property (
        flush_set && !data_wr |=> tx_buffer_empty) else $error("flush left byte");
    read_clear_a: assert property (
        data_rd |=> !rx_buffer_full) else $error("read left full flag");
    // SDA may move under high SCL only for a start or a stop
    sda_hold_a: assert property (
        $changed(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> start_pending || stop_pending
        || $past(start_pending) || $past(stop_pending)) else $error("SDA moved under high SCL");
    stop_clear_a: assert property (
        $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> ##[0:40] !stop_pending) else $error("stop bit stuck");
    nack_ack_a: assert property (
        $rose(nack_irq_flag) && !read_flag |-> !ack_flag) else $error("nack with ack set");
    nack_pend_a: assert property (
        $rose(nack_irq_flag) |-> !$past(stop_pending) && !$past(start_pending)) else $error("nack while ending");
    nack_stop_a: assert property (
        $fell(nack_irq_flag) |-> ##[0:1] !stop_pending) else $error("nack cleared early");
    rx_irq_a: assert property (
        $rose(rx_buffer_full) && controller_enable |-> ##2 irq) else $error("no receive irq");
endmodule // imt_i2c_master_chk

bind imt_i2c_master imt_i2c_master_chk u_imt_i2c_master_chk (.sys_clk(sys_clk), .rstn(rstn),
    .controller_enable(controller_enable), .transmit_irq_enable(transmit_irq_enable), .flush_set(flush_set),
    .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd), .data_out(data_out),
    .tx_buffer_empty(tx_buffer_empty), .rx_buffer_full(rx_buffer_full), .ack_flag(ack_flag),
    .nack_irq_flag(nack_irq_flag), .read_flag(read_flag), .start_pending(start_pending),
    .stop_pending(stop_pending),
    .irq(irq), .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n));

// ---- test/imt_slave_model.sv ----
`timescale 1ns/1ps
// ****************
// Behavioural slave on the bus
// ****************
module imt_slave_model (
    input wire scl,
    input wire sda,
    input wire ack_en,
    input wire [7:0] rd_data,
    output logic sda_pull,
    output logic [8:0] unit,
    output logic unit_v
);
    int bits = 0; // SCL rises seen in this unit
    logic first = 1'b0; // Next unit is an address byte
    logic reading = 1'b0; // Slave sends data bytes
    logic [8:0] sh = 9'h000; // Byte plus ack bit
    initial sda_pull = 1'b0;
    initial unit = 9'h000;
    initial unit_v = 1'b0;
    // Start: SDA falls while SCL is high
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            bits = 0;
            first = 1'b1;
            reading = 1'b0;
        end
    // Capture every bit on the line, MSB first
    always @(posedge scl)
    begin
        sh = {sh[7:0], sda};
        bits = bits + 1;
        if (bits == 9)
        begin
            unit = sh;
            unit_v = 1'b1;
            bits = 0;
            if (first)
                reading = sh[1] && !sh[0]; // Only an acknowledged read address turns the bus
            else if (reading && sh[0])
                reading = 1'b0; // Refused: let go so a stop can be seen
            first = 1'b0;
        end
    end
    // Change SDA only while SCL is low
    always @(negedge scl)
    begin
        unit_v = 1'b0;
        if (bits == 8)
            sda_pull = !reading && ack_en;
        else if (reading && !first)
            sda_pull = ~rd_data[7 - bits];
        else
            sda_pull = 1'b0;
    end
endmodule // imt_slave_model

// ---- test/i2c_master_transfer_sequencer_tb.sv ----
`timescale 1ns/1ps
// ****************
// Bench: 10-bit write, refused address, 7-bit read
// ****************
module i2c_master_transfer_sequencer_tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic en = 1'b0;
    logic txie = 1'b0;
    logic [5:0] ctl = 6'h00; // Pulses: read, write, nak, flush, stop, start
    logic [7:0] din = 8'h00;
    logic [7:0] rdd = 8'h00; // Byte the slave returns
    logic ack_en = 1'b1;
    wire [7:0] dout;
    wire tx_e, rx_f, ackf, nckf, tenf, rdf, stp, irq, sda_oe_n, scl_oe_n, sda_pull, unit_v;
    wire stt, nkp, so, co;
    wire [8:0] unit;
    wire sda = sda_oe_n & ~sda_pull; // Open drain with pull-up
    logic [8:0] exp_q[$]; // Units expected on the wire
    int miscompares = 0;
    int checks_done = 0;
    initial forever #50 sys_clk = ~sys_clk;
    imt_i2c_master #(.QUARTER_NS(400)) u_imt_i2c_master (.sys_clk(sys_clk), .rstn(rstn),
        .controller_enable(en), .transmit_irq_enable(txie), .start_set(ctl[0]), .stop_set(ctl[1]),
        .flush_set(ctl[2]), .nak_set(ctl[3]), .data_wr(ctl[4]), .data_in(din), .data_rd(ctl[5]),
        .data_out(dout), .tx_buffer_empty(tx_e), .rx_buffer_full(rx_f), .ack_flag(ackf),
        .nack_irq_flag(nckf), .ten_bit_flag(tenf), .read_flag(rdf), .start_pending(stt),
        .stop_pending(stp), .nak_pending(nkp), .irq(irq), .sda_i(sda), .sda_o(so), .sda_oe_n(sda_oe_n),
        .scl_o(co), .scl_oe_n(scl_oe_n));
    imt_slave_model u_imt_slave_model (.scl(scl_oe_n), .sda(sda), .ack_en(ack_en), .rd_data(rdd),
        .sda_pull(sda_pull), .unit(unit), .unit_v(unit_v));
    task check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One-cycle control pulse; interrupt enable changes with it
    task pulse(input logic [5:0] v, input logic ie);
        @(negedge sys_clk);
        ctl = v;
        txie = ie;
        @(negedge sys_clk);
        ctl = 6'h00;
    endtask
    // Bounded wait: 0 empty, 1 stop pending, 2 nack, 3 full
    task wait_for(input int sel, input logic lvl);
        logic [3:0] w;
        for (int n = 0; n < 3000; n++)
        begin
            @(negedge sys_clk);
            w = {rx_f, nckf, stp, tx_e};
            if (w[sel] === lvl)
                return;
        end
        check(9'h000, 9'h001);
        close_out;
    endtask
    // Each unit the slave sees takes the oldest note
    always @(posedge unit_v)
        check(unit, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
    initial
    begin
        logic [7:0] a2, d1, r1, r2;
        void'($urandom(32'hdc34));
        a2 = 8'($urandom);
        d1 = 8'($urandom);
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        check({rx_f, ackf, nckf, tx_e}, 4'h1);
        @(negedge sys_clk) en = 1'b1;
        @(negedge sys_clk) txie = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(irq, 1'b1);
        // 10-bit write; last byte refused while stop is pending
        exp_q = '{{8'hf2, 1'b0}, {a2, 1'b0}, {d1, 1'b1}, {8'hf6, 1'b1}};
        din = 8'hf2;
        pulse(6'h10, 1'b1);
        pulse(6'h01, 1'b1);
        wait_for(0, 1'b1);
        check(u_imt_slave_model.bits[8:0], 9'h001);
        din = a2;
        pulse(6'h10, 1'b1);
        wait_for(0, 1'b1);
        check({ackf, tenf}, 2'b11);
        din = d1;
        pulse(6'h10, 1'b1);
        wait_for(0, 1'b1);
        ack_en = 1'b0;
        pulse(6'h02, 1'b0);
        wait_for(1, 1'b0);
        check({ackf, nckf}, 2'b00);
        // First address byte refused, then abandoned
        din = 8'hf6;
        pulse(6'h10, 1'b1);
        pulse(6'h01, 1'b1);
        wait_for(2, 1'b1);
        @(negedge sys_clk);
        check({ackf, irq}, 2'b01);
        din = a2;
        pulse(6'h10, 1'b1);
        pulse(6'h06, 1'b0);
        check(tx_e, 1'b1);
        wait_for(1, 1'b0);
        check(nckf, 1'b0);
        // 7-bit read address refused, then abandoned
        din = {1'b0, a2[5:0], 1'b1};
        exp_q = '{{din, 1'b1}, {din, 1'b0}, {r1, 1'b0}, {r2, 1'b1}};
        pulse(6'h10, 1'b0);
        pulse(6'h01, 1'b0);
        wait_for(2, 1'b1);
        check({ackf, rdf, stt}, 3'b010);
        pulse(6'h02, 1'b0);
        wait_for(1, 1'b0);
        check(nckf, 1'b0);
        // 7-bit read of two bytes, the second refused
        ack_en = 1'b1;
        rdd = r1;
        pulse(6'h10, 1'b0);
        pulse(6'h01, 1'b0);
        wait_for(3, 1'b1);
        check({dout, rdf}, {r1, 1'b1});
        rdd = r2;
        pulse(6'h08, 1'b0);
        pulse(6'h20, 1'b0);
        check(rx_f, 1'b0);
        wait_for(3, 1'b1);
        check(dout, r2);
        wait_for(2, 1'b1);
        pulse(6'h20, 1'b0);
        pulse(6'h02, 1'b0);
        wait_for(1, 1'b0);
        check({nckf, nkp, stt, so, co, exp_q.size() == 0}, 6'h01);
        close_out;
    end
endmodule // i2c_master_transfer_sequencer_tb
